// ==== iem_pkg.sv ====
/*
  Constants for the internal error report mask block: register offsets,
  field layouts, reset values and register selector type.
  Assumes a 32-bit APB register bus and one 250 MHz core clock.
*/
// Contract
// - A set mask bit keeps its status bit from raising an error report.
// - Mask writes never change status bits; errors keep latching regardless.
// - Mask bits 0..2 gate ingress posted, non-posted, completion time-outs; bit 3 zero.
// - Mask bits 4..6 gate egress posted, non-posted, completion time-outs.
// - Mask bits 7..14 gate single then double ECC errors of four buffer RAMs.
// - Bit 15 gates end-to-end parity error; bit 16 gates unreliable link flag.
// - Bits 17, 18 gate replay control RAM single, double ECC; 31..19 read zero.
// - Unmasked errors are reported only while the global enable, default one, is set.
// - Set unmasked bit reports uncorrectable if severity bit is one, else correctable.
package iem_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ERR_W  = 19;

  // Register byte offsets
  localparam logic [11:0] OFS_CTL  = 12'h480;
  localparam logic [11:0] OFS_STS  = 12'h484;
  localparam logic [11:0] OFS_MSK  = 12'h488;
  localparam logic [11:0] OFS_SEV  = 12'h48C;
  localparam logic [11:0] OFS_ISTS = 12'h490;
  localparam logic [11:0] OFS_IMSK = 12'h494;

  // Implemented bits of the error status, mask and severity registers
  localparam logic [31:0] ERR_BITS = 32'h0007_FFF7;

  // Control register fields
  localparam int unsigned CTL_EN_POS = 0;
  localparam logic [31:0] CTL_BITS   = 32'h0000_0001;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_UNCOR_POS = 0;
  localparam int unsigned IRQ_COR_POS   = 1;
  localparam logic [31:0] IRQ_BITS      = 32'h0000_0003;

  // Reset values
  localparam logic [31:0] RST_CTL  = 32'h0000_0001;
  localparam logic [31:0] RST_STS  = 32'h0000_0000;
  localparam logic [31:0] RST_MSK  = 32'h0000_0000;
  localparam logic [31:0] RST_SEV  = 32'h0000_0511;
  localparam logic [31:0] RST_ISTS = 32'h0000_0000;
  localparam logic [31:0] RST_IMSK = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEL_CTL,
    SEL_STS,
    SEL_MSK,
    SEL_SEV,
    SEL_ISTS,
    SEL_IMSK,
    SEL_NONE
  } iem_sel_t;

  typedef enum logic {
    ST_IDLE,
    ST_ACCESS
  } iem_apb_st_t;

endpackage : iem_pkg

// ==== iem_mask_top.sv ====
/*
  Internal error report mask block: error status flags, report mask,
  severity select, global report enable and interrupt logic, all behind
  an APB slave with zero wait states.
  Assumes APB signals and error event pulses synchronous to ref_clk;
  rstn is the fundamental reset, hot_rst a synchronous non-fundamental one.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

module iem_mask_top
#(
  parameter int unsigned ADDR_W = 12
)
(
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire logic                       hot_rst,

  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ADDR_W-1:0]          paddr,
  input  wire logic [iem_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [iem_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,

  // Error detection pulses
  input  wire logic [iem_pkg::DATA_W-1:0] err_event,

  // Report toward the error reporting capability
  output logic                            uncor_report,
  output logic                            cor_report,

  // Status view and interrupt
  output logic      [iem_pkg::DATA_W-1:0] status_flags,
  output logic                            irq
);
  import iem_pkg::*;

  generate
    if (ADDR_W < 12)
    begin : g_addr_chk
      $error("ADDR_W must be at least 12");
    end
  endgenerate

  // Address decode
  function automatic iem_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    iem_sel_t s;
    s = SEL_NONE;
    if ((a >> 12) == '0)
    begin
      case (a[11:0])
        OFS_CTL:  s = SEL_CTL;
        OFS_STS:  s = SEL_STS;
        OFS_MSK:  s = SEL_MSK;
        OFS_SEV:  s = SEL_SEV;
        OFS_ISTS: s = SEL_ISTS;
        OFS_IMSK: s = SEL_IMSK;
        default:  s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : reg_sel

  // Byte strobes to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] st);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{st[i]}};
    end
    return m;
  endfunction : strb_mask

  // Registers
  iem_apb_st_t        st_r;
  iem_apb_st_t        st_nxt;
  logic [31:0]        prdata_r;
  logic [31:0]        prdata_nxt;
  logic               pready_r;
  logic               pready_nxt;
  logic               pslverr_r;
  logic               pslverr_nxt;
  logic [31:0]        ctl_r;
  logic [31:0]        ctl_nxt;
  logic [31:0]        sts_r;
  logic [31:0]        sts_nxt;
  logic [31:0]        msk_r;
  logic [31:0]        msk_nxt;
  logic [31:0]        sev_r;
  logic [31:0]        sev_nxt;
  logic [31:0]        ists_r;
  logic [31:0]        ists_nxt;
  logic [31:0]        imsk_r;
  logic [31:0]        imsk_nxt;
  logic               uncor_r;
  logic               uncor_nxt;
  logic               cor_r;
  logic               cor_nxt;
  logic               irq_r;
  logic               irq_nxt;

  // Bus decode
  iem_sel_t           sel;
  logic               wr_go;
  logic [31:0]        wmask;
  logic [31:0]        w1c;
  logic [31:0]        report_src;
  logic [31:0]        ev_set;

  assign sel     = reg_sel(paddr);
  assign wr_go   = (st_r == ST_ACCESS) && psel && penable && pwrite
                   && pready_r && (sel != SEL_NONE);
  assign wmask   = strb_mask(pstrb);
  assign w1c     = pwdata & wmask;

  // Only implemented error bits latch
  assign ev_set  = err_event & ERR_BITS;

  // Status bits that may report: set and not masked
  assign report_src = sts_r & ~msk_r & ERR_BITS;

  // APB handshake
  always_comb
  begin
    st_nxt      = st_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    case (st_r)
      ST_IDLE:
      begin
        if (psel && !penable)
        begin
          st_nxt      = ST_ACCESS;
          pready_nxt  = 1'b1;
          pslverr_nxt = (sel == SEL_NONE);
          case (sel)
            SEL_CTL:  prdata_nxt = ctl_r & CTL_BITS;
            SEL_STS:  prdata_nxt = sts_r & ERR_BITS;
            SEL_MSK:  prdata_nxt = msk_r & ERR_BITS;
            SEL_SEV:  prdata_nxt = sev_r & ERR_BITS;
            SEL_ISTS: prdata_nxt = ists_r & IRQ_BITS;
            SEL_IMSK: prdata_nxt = imsk_r & IRQ_BITS;
            default:  prdata_nxt = 32'h0000_0000;
          endcase
        end
      end
      ST_ACCESS:
      begin
        if (psel && penable && pready_r)
        begin
          st_nxt = ST_IDLE;
        end
        else
        begin
          pready_nxt  = pready_r;
          pslverr_nxt = pslverr_r;
        end
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r      <= ST_IDLE;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Software-retained configuration: only the fundamental reset returns it to its reset values
  always_comb
  begin
    ctl_nxt = ctl_r;
    msk_nxt = msk_r;
    sev_nxt = sev_r;
    if (wr_go && sel == SEL_CTL)
    begin
      ctl_nxt = ((ctl_r & ~wmask) | (pwdata & wmask)) & CTL_BITS;
    end
    if (wr_go && sel == SEL_MSK)
    begin
      msk_nxt = ((msk_r & ~wmask) | (pwdata & wmask)) & ERR_BITS;
    end
    if (wr_go && sel == SEL_SEV)
    begin
      sev_nxt = ((sev_r & ~wmask) | (pwdata & wmask)) & ERR_BITS;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_r <= RST_CTL;
      msk_r <= RST_MSK;
      sev_r <= RST_SEV;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      msk_r <= msk_nxt;
      sev_r <= sev_nxt;
    end
  end

  // Error status flags: set wins over write-one-clear, mask not involved
  generate
    for (genvar b = 0; b < DATA_W; b++)
    begin : g_sts
      always_comb
      begin
        sts_nxt[b] = sts_r[b];
        if (wr_go && sel == SEL_STS && w1c[b])
        begin
          sts_nxt[b] = 1'b0;
        end
        if (ev_set[b])
        begin
          sts_nxt[b] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sts_r <= RST_STS;
    end
    else
    begin
      sts_r <= sts_nxt;
    end
  end

  // Report levels toward the error reporting capability
  always_comb
  begin
    uncor_nxt = ctl_r[CTL_EN_POS] && |(report_src & sev_r);
    cor_nxt   = ctl_r[CTL_EN_POS] && |(report_src & ~sev_r);
  end

  // Interrupt status (write one to clear), mask and output
  always_comb
  begin
    ists_nxt = ists_r;
    imsk_nxt = imsk_r;
    if (wr_go && sel == SEL_ISTS)
    begin
      ists_nxt = ists_r & ~w1c;
    end
    if (wr_go && sel == SEL_IMSK)
    begin
      imsk_nxt = ((imsk_r & ~wmask) | (pwdata & wmask)) & IRQ_BITS;
    end
    if (uncor_nxt && !uncor_r)
    begin
      ists_nxt[IRQ_UNCOR_POS] = 1'b1;
    end
    if (cor_nxt && !cor_r)
    begin
      ists_nxt[IRQ_COR_POS] = 1'b1;
    end
    ists_nxt = ists_nxt & IRQ_BITS;
    irq_nxt  = |(ists_nxt & ~imsk_nxt);
    if (hot_rst)
    begin
      ists_nxt = RST_ISTS;
      imsk_nxt = RST_IMSK;
      irq_nxt  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      uncor_r <= 1'b0;
      cor_r   <= 1'b0;
      ists_r  <= RST_ISTS;
      imsk_r  <= RST_IMSK;
      irq_r   <= 1'b0;
    end
    else
    begin
      uncor_r <= uncor_nxt;
      cor_r   <= cor_nxt;
      ists_r  <= ists_nxt;
      imsk_r  <= imsk_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // Outputs
  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign uncor_report = uncor_r;
  assign cor_report   = cor_r;
  assign status_flags = sts_r;
  assign irq          = irq_r;

endmodule : iem_mask_top

// ==== iem_mask_monitor.sv ====
/* Port checker for the report mask block.
   Assumes it is bound onto iem_mask_top and its one clock domain. */
`timescale 1ns/1ps
module iem_mask_monitor
import iem_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        hot_rst,
  // Register bus and events
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] err_event,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Reports and status
  input wire logic        uncor_report,
  input wire logic        cor_report,
  input wire logic [31:0] status_flags,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_resp: assert property (pslverr |-> pready && prdata == 0)
    else $error("bad error response");
  chk_status_set: assert property (err_event != 0 |=>
    (status_flags & $past(err_event) & ERR_BITS)
    == ($past(err_event) & ERR_BITS))
    else $error("status not latched");
  chk_reserved_zero: assert property ((status_flags & ~ERR_BITS) == 0)
    else $error("reserved status bit set");
  chk_quiet_report: assert property (status_flags == 0 |=>
    !uncor_report && !cor_report)
    else $error("report without status");
  chk_hot_keep: assert property (hot_rst && err_event == 0 && !psel
    |=> $stable(status_flags))
    else $error("status lost on hot reset");
  chk_hot_irq: assert property (hot_rst |=> !irq)
    else $error("irq survived hot reset");
endmodule : iem_mask_monitor

bind iem_mask_top iem_mask_monitor u_mon (.ref_clk(ref_clk), .rstn(rstn),
  .hot_rst(hot_rst), .psel(psel), .penable(penable),
  .err_event(err_event), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .uncor_report(uncor_report),
  .cor_report(cor_report), .status_flags(status_flags), .irq(irq));

// ==== iem_aer_model.sv ====
/* Receiving end of the report levels: counts each report raised.
   Assumes levels synchronous to ref_clk. */
`timescale 1ns/1ps
module iem_aer_model
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Report levels
  input  wire logic uncor_report,
  input  wire logic cor_report,
  // Counts of raised reports
  output int        uncor_cnt,
  output int        cor_cnt
);
  logic uncor_q;
  logic cor_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      uncor_q   <= 1'b0;
      cor_q     <= 1'b0;
      uncor_cnt <= 0;
      cor_cnt   <= 0;
    end
    else
    begin
      uncor_q <= uncor_report;
      cor_q   <= cor_report;
      if (uncor_report && !uncor_q)
        uncor_cnt <= uncor_cnt + 1;
      if (cor_report && !cor_q)
        cor_cnt <= cor_cnt + 1;
    end
  end
endmodule : iem_aer_model

// ==== tb_internal_error_report_mask.sv ====
/* Testbench for the report mask block.
   Assumes APB zero wait slave and reports one edge after a change. */
`timescale 1ns/1ps
module tb_internal_error_report_mask;
  import iem_pkg::*;
  logic        ref_clk = 0, rstn = 0, hot_rst = 0;
  logic        psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, err_event = '0, rd;
  logic [31:0] prdata, status_flags;
  logic        pready, pslverr, uncor_report, cor_report, irq;
  int          mismatches = 0, checks = 0, cyc = 0, uc, cc;

  iem_mask_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .hot_rst(hot_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_event(err_event),
    .uncor_report(uncor_report), .cor_report(cor_report),
    .status_flags(status_flags), .irq(irq));
  iem_aer_model u_aer (.ref_clk(ref_clk), .rstn(rstn),
    .uncor_report(uncor_report), .cor_report(cor_report),
    .uncor_cnt(uc), .cor_cnt(cc));

  initial forever #2 ref_clk = ~ref_clk;

  task close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      close_out();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, '0);
    chk(rd, exp);
  endtask : rdc

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task t_reset;
    rdc(OFS_CTL, RST_CTL);
    rdc(OFS_MSK, 32'h0000_0000);
    rdc(OFS_STS, 32'h0000_0000);
    apb(0, 12'h4A0, '0);
    chk(32'(se), 32'h0000_0001);
    apb(1, OFS_MSK, 32'hFFFF_FFFF);
    rdc(OFS_MSK, ERR_BITS);
    $display("test reset done");
  endtask : t_reset

  task t_gate;
    for (int b = 0; b < 32; b++)
      if (ERR_BITS[b])
      begin
        @(posedge ref_clk) err_event <= 32'h1 << b;
        @(posedge ref_clk) err_event <= '0;
        tick(3);
        chk(status_flags, 32'h1 << b);
        chk(32'({uncor_report, cor_report}), 32'h0);
        apb(1, OFS_MSK, ERR_BITS & ~(32'h1 << b));
        tick(2);
        chk(32'({uncor_report, cor_report}),
          32'({RST_SEV[b], !RST_SEV[b]}));
        chk(status_flags, 32'h1 << b);
        apb(1, OFS_MSK, ERR_BITS);
        apb(1, OFS_STS, 32'h1 << b);
        tick(2);
      end
    chk(32'(uc + cc), 32'd18);
    $display("test gate done");
  endtask : t_gate

  task t_irq_en;
    apb(1, OFS_ISTS, 32'h0000_0003);
    tick(2);
    chk(32'(irq), 32'h0);
    @(posedge ref_clk) err_event <= 32'h0000_0001;
    @(posedge ref_clk) err_event <= '0;
    apb(1, OFS_MSK, ERR_BITS & ~32'h1);
    tick(3);
    chk(32'(irq), 32'h1);
    apb(1, OFS_IMSK, 32'h0000_0001);
    tick(2);
    chk(32'(irq), 32'h0);
    apb(1, OFS_IMSK, 32'h0000_0000);
    tick(2);
    chk(32'(irq), 32'h1);
    apb(1, OFS_ISTS, 32'h0000_0001);
    tick(2);
    chk(32'(irq), 32'h0);
    apb(1, OFS_CTL, 32'h0000_0000);
    tick(2);
    chk(32'(uncor_report), 32'h0);
    apb(1, OFS_CTL, 32'h0000_0001);
    tick(2);
    chk(32'(uncor_report), 32'h1);
    $display("test irq and enable done");
  endtask : t_irq_en

  task t_hot;
    apb(1, OFS_MSK, 32'h0000_0005);
    @(posedge ref_clk) hot_rst <= 1;
    @(posedge ref_clk) hot_rst <= 0;
    tick(2);
    chk(32'(irq), 32'h0);
    rdc(OFS_MSK, 32'h0000_0005);
    $display("test hot reset done");
  endtask : t_hot

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1;
    t_reset();
    t_gate();
    t_irq_en();
    t_hot();
    close_out();
  end
endmodule : tb_internal_error_report_mask
